// file: bench/cab_core_tb.sv
/*
 * Self-checking bench for cab_core: arithmetic, logic, word, flow,
 * skip and single-bit I/O operations with flags and cycle counts.
 * Assumes the package and design files of logic/ are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module cab_core_tb;
	import cab_pkg::*;

	logic        clk_i;
	logic        sys_rst_i;
	logic        start_i;
	cab_op_t     op_i;
	logic [7:0]  rd_i;
	logic [7:0]  rr_i;
	logic [7:0]  imm_i;
	logic [15:0] pair_i;
	logic [5:0]  word_imm_i;
	logic [7:0]  sreg_i;
	logic [15:0] pc_i;
	logic [15:0] z_i;
	logic [11:0] offset_i;
	logic        next_two_word_i;
	logic [15:0] stack_data_i;
	logic [5:0]  io_addr_i;
	logic [2:0]  io_bit_i;
	logic [7:0]  io_rdata_i;
	logic        ready_o;
	logic        done_o;
	logic [7:0]  rd_data_o;
	logic        rd_we_o;
	logic [15:0] pair_data_o;
	logic        pair_we_o;
	logic [7:0]  sreg_o;
	logic [15:0] pc_o;
	logic        stack_push_o;
	logic        stack_pop_o;
	logic [15:0] push_data_o;
	logic        io_we_o;
	logic [5:0]  io_addr_o;
	logic [7:0]  io_wmask_o;
	logic [7:0]  io_wdata_o;
	logic        io_refused_o;
	int          bad_count;
	int          tests_run;
	int          lat;

	cab_core i_cab_core (
		.clk_i          (clk_i),
		.sys_rst_i      (sys_rst_i),
		.start_i        (start_i),
		.op_i           (op_i),
		.rd_i           (rd_i),
		.rr_i           (rr_i),
		.imm_i          (imm_i),
		.pair_i         (pair_i),
		.word_imm_i     (word_imm_i),
		.sreg_i         (sreg_i),
		.pc_i           (pc_i),
		.z_i            (z_i),
		.offset_i       (offset_i),
		.next_two_word_i(next_two_word_i),
		.stack_data_i   (stack_data_i),
		.io_addr_i      (io_addr_i),
		.io_bit_i       (io_bit_i),
		.io_rdata_i     (io_rdata_i),
		.ready_o        (ready_o),
		.done_o         (done_o),
		.rd_data_o      (rd_data_o),
		.rd_we_o        (rd_we_o),
		.pair_data_o    (pair_data_o),
		.pair_we_o      (pair_we_o),
		.sreg_o         (sreg_o),
		.pc_o           (pc_o),
		.stack_push_o   (stack_push_o),
		.stack_pop_o    (stack_pop_o),
		.push_data_o    (push_data_o),
		.io_we_o        (io_we_o),
		.io_addr_o      (io_addr_o),
		.io_wmask_o     (io_wmask_o),
		.io_wdata_o     (io_wdata_o),
		.io_refused_o   (io_refused_o)
	);

	// -------------------------------------------------
	// shared tasks
	// -------------------------------------------------
	task chk(input logic [15:0] s, input logic [15:0] e);
	begin
		tests_run++;
		if (s !== e)
		begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	end
	endtask

	task end_sim;
	begin
		$display("checks=%0d mismatches=%0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask

	// one request; returns in the done cycle with lat = cycles taken
	task go(input cab_op_t op);
	begin
		@(posedge clk_i);
		#1;
		op_i = op;
		start_i = 1'b1;
		@(posedge clk_i);
		#1;
		start_i = 1'b0;
		lat = 1;
		while (done_o !== 1'b1 && lat < 8)
		begin
			@(posedge clk_i);
			#1;
			lat++;
		end
	end
	endtask

	task alu(input cab_op_t op, input logic [7:0] a, b, r, f);
	begin
		rd_i = a;
		rr_i = b;
		imm_i = b;
		go(op);
		chk(lat, 1);
		chk(rd_data_o, r);
		chk(sreg_o, f);
	end
	endtask

	task flow(input cab_op_t op, input int n, input logic [15:0] p,
		input logic [7:0] f);
	begin
		go(op);
		chk(lat, n);
		chk(pc_o, p);
		chk(sreg_o, f);
	end
	endtask

	// -------------------------------------------------
	// scenarios
	// -------------------------------------------------
	task t_arith;
	begin
		sreg_i = 8'h01;
		alu(CAB_OP_SUM, 8'h08, 8'h08, 8'h10, 8'h20);
		alu(CAB_OP_DIFFERENCE, 8'h00, 8'h01, 8'hFF, 8'h25);
		alu(CAB_OP_SUM_CARRY, 8'h0F, 8'h70, 8'h80, 8'h2C);
		chk(rd_we_o, 1'b1);
		alu(CAB_OP_DIFF_BORROW_IMM, 8'h00, 8'h00, 8'hFF, 8'h25);
		alu(CAB_OP_DIFF_BORROW, 8'h80, 8'h00, 8'h7F, 8'h28);
		alu(CAB_OP_DIFFERENCE_IMM, 8'h10, 8'h10, 8'h00, 8'h02);
		alu(CAB_OP_TWOS_INVERSION, 8'h01, 8'h00, 8'hFF, 8'h25);
		alu(CAB_OP_ONES_INVERSION, 8'h00, 8'h00, 8'hFF, 8'h05);
		alu(CAB_OP_MINUS_ONE, 8'h80, 8'h00, 8'h7F, 8'h09);
		alu(CAB_OP_PLUS_ONE, 8'h7F, 8'h00, 8'h80, 8'h0D);
	end
	endtask

	task t_logic;
	begin
		sreg_i = 8'h29;
		alu(CAB_OP_CONJUNCTION, 8'hC3, 8'h81, 8'h81, 8'h25);
		alu(CAB_OP_DISJUNCTION, 8'h00, 8'h00, 8'h00, 8'h23);
		alu(CAB_OP_REGISTER_ZEROING, 8'h5A, 8'h00, 8'h00, 8'h23);
		alu(CAB_OP_REGISTER_ALL_ONES, 8'h00, 8'h00, 8'hFF, 8'h29);
		alu(CAB_OP_CONJUNCTION_IMM, 8'hF0, 8'h0F, 8'h00, 8'h23);
		alu(CAB_OP_DISJUNCTION_IMM, 8'h00, 8'h80, 8'h80, 8'h25);
		alu(CAB_OP_EXCL_DISJUNCTION, 8'h5A, 8'h5A, 8'h00, 8'h23);
		alu(CAB_OP_BITS_SET_MASK, 8'h01, 8'h80, 8'h81, 8'h25);
		alu(CAB_OP_BITS_CLEAR_MASK, 8'hFF, 8'h0F, 8'hF0, 8'h25);
		rd_i = 8'h80;
		rr_i = 8'h00;
		go(CAB_OP_ZERO_SIGN_CHECK);
		chk(sreg_o, 8'h25);
		chk(rd_data_o, 8'h80);
		chk(rd_we_o, 1'b0);
	end
	endtask

	task t_word;
	begin
		sreg_i = 8'h00;
		pair_i = 16'hFFFF;
		word_imm_i = 6'h01;
		go(CAB_OP_WORD_SUM_IMM);
		chk(lat, 2);
		chk(pair_data_o, 16'h0000);
		chk(sreg_o, 8'h03);
		chk(pair_we_o, 1'b1);
		pair_i = 16'h8000;
		go(CAB_OP_WORD_DIFF_IMM);
		chk(lat, 2);
		chk(pair_data_o, 16'h7FFF);
		chk(sreg_o, 8'h18);
	end
	endtask

	task t_flow;
	begin
		sreg_i = 8'h25;
		pc_i = 16'h0100;
		z_i = 16'h1234;
		offset_i = 12'hFFE;
		stack_data_i = 16'h0456;
		flow(CAB_OP_REL_BRANCH, 2, 16'h00FF, 8'h25);
		flow(CAB_OP_REL_SUB_ENTRY, 3, 16'h00FF, 8'h25);
		chk(push_data_o, 16'h0101);
		flow(CAB_OP_POINTER_BRANCH, 2, 16'h1234, 8'h25);
		flow(CAB_OP_PTR_SUB_ENTRY, 3, 16'h1234, 8'h25);
		chk(stack_push_o, 1'b1);
		flow(CAB_OP_SUBROUTINE_EXIT, 4, 16'h0456, 8'h25);
		chk(stack_pop_o, 1'b1);
		flow(CAB_OP_HANDLER_EXIT, 4, 16'h0456, 8'hA5);
		rd_i = 8'h33;
		rr_i = 8'h33;
		next_two_word_i = 1'b1;
		flow(CAB_OP_EQUAL_SKIP, 3, 16'h0103, 8'h25);
		next_two_word_i = 1'b0;
		flow(CAB_OP_EQUAL_SKIP, 2, 16'h0102, 8'h25);
		rr_i = 8'h34;
		flow(CAB_OP_EQUAL_SKIP, 1, 16'h0101, 8'h25);
	end
	endtask

	task t_io;
	begin
		io_addr_i = 6'h1F;
		io_bit_i = 3'h3;
		io_rdata_i = 8'hF0;
		go(CAB_OP_IO_BIT_SET);
		chk(lat, 2);
		chk(io_we_o, 1'b1);
		chk(io_addr_o, 6'h1F);
		chk(io_wmask_o, 8'h08);
		chk(io_wdata_o, 8'h08);
		go(CAB_OP_IO_BIT_CLEAR);
		chk(io_wmask_o, 8'h08);
		chk(io_wdata_o, 8'h00);
		io_addr_i = 6'h20;
		go(CAB_OP_IO_BIT_SET);
		chk(io_we_o, 1'b0);
		chk(io_refused_o, 1'b1);
		io_rdata_i = 8'h08;
		flow(CAB_OP_IO_BIT_HIGH_SKIP, 1, 16'h0101, 8'h25);
		chk(io_refused_o, 1'b1);
		io_addr_i = 6'h05;
		flow(CAB_OP_IO_BIT_HIGH_SKIP, 2, 16'h0102, 8'h25);
		flow(CAB_OP_IO_BIT_LOW_SKIP, 1, 16'h0101, 8'h25);
		io_rdata_i = 8'hF7;
		next_two_word_i = 1'b1;
		flow(CAB_OP_IO_BIT_LOW_SKIP, 3, 16'h0103, 8'h25);
	end
	endtask

	// -------------------------------------------------
	// clock, watchdog and main sequence
	// -------------------------------------------------
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	initial
	begin
		#(20 * 5000);
		bad_count++;
		end_sim;
	end

	initial
	begin
		bad_count = 0;
		tests_run = 0;
		sys_rst_i = 1'b1;
		start_i = 1'b0;
		op_i = CAB_OP_SUM;
		rd_i = 8'h00;
		rr_i = 8'h00;
		imm_i = 8'h00;
		pair_i = 16'h0000;
		word_imm_i = 6'h00;
		sreg_i = 8'h00;
		pc_i = 16'h0000;
		z_i = 16'h0000;
		offset_i = 12'h000;
		next_two_word_i = 1'b0;
		stack_data_i = 16'h0000;
		io_addr_i = 6'h00;
		io_bit_i = 3'h0;
		io_rdata_i = 8'h00;
		repeat (4) @(posedge clk_i);
		#1;
		sys_rst_i = 1'b0;
		chk(ready_o, 1'b1);
		chk(done_o, 1'b0);
		chk(pc_o, 16'h0000);
		t_arith;
		t_logic;
		t_word;
		t_flow;
		t_io;
		end_sim;
	end
endmodule // cab_core_tb

`default_nettype wire

// file: logic/cab_addsub8.sv
/*
 * Eight-bit adder and subtractor with carry or borrow in, giving the
 * result and the half-carry, overflow and carry flags.
 * Assumes operands are stable while the core samples the outputs.
 */
`timescale 1ns/1ps
`default_nettype none

module cab_addsub8 (
	input  wire logic       sub_i,
	input  wire logic [7:0] a_i,
	input  wire logic [7:0] b_i,
	input  wire logic       cin_i,
	output logic      [7:0] res_o,
	output logic            half_o,
	output logic            ovf_o,
	output logic            carry_o
);

	wire logic [8:0] full_add;
	wire logic [8:0] full_sub;
	wire logic [4:0] low_add;
	wire logic [4:0] low_sub;

	assign full_add = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i};
	assign full_sub = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin_i};
	assign low_add  = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
	assign low_sub  = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, cin_i};

	assign res_o   = sub_i ? full_sub[7:0] : full_add[7:0];
	assign carry_o = sub_i ? full_sub[8] : full_add[8];
	assign half_o  = sub_i ? low_sub[4] : low_add[4];
	// signed overflow: operand signs versus result sign
	assign ovf_o   = sub_i
		? (a_i[7] & ~b_i[7] & ~res_o[7]) | (~a_i[7] & b_i[7] & res_o[7])
		: (a_i[7] & b_i[7] & ~res_o[7]) | (~a_i[7] & ~b_i[7] & res_o[7]);

endmodule // cab_addsub8

`default_nettype wire

// file: logic/cab_core.sv
/*
 * Execution unit for arithmetic, logic, word arithmetic, program flow
 * and single-bit I/O instructions of an 8-bit core.
 * Assumes the surroundings hold the register file, stack and I/O space,
 * present operands with start_i and apply results while done_o is high.
 */
// Overview of operation
// RULE1: software writes reserved bits as zero
// RULE2: software never writes reserved I/O addresses
// RULE3: bit set/clear only at I/O 0x00-0x1F
// RULE4: bit test and skip in low range
// RULE5: bit set/clear writes only addressed bit
// RULE6: add with carry, five flags, one clock
// RULE7: word add immediate, sign flags, two clocks
// RULE8: word subtract immediate, two clocks
// RULE9: subtract with borrow, both forms, one clock
// RULE10: subtract constant, five flags, one clock
// RULE11: logic ops keep carry and half-carry
// RULE12: set bits by OR mask, one clock
// RULE13: clear bits by AND inverse mask
// RULE14: test ANDs register with itself, flags only
// RULE15: pointer jump loads PC from Z, two clocks
// RULE16: pointer call saves return, three clocks
// RULE17: equal skip advances PC two or three
// RULE18: ones and twos inversion, one clock
// RULE19: increment/decrement keep carry, one clock
// RULE20: relative jump/call to PC plus offset plus one
// RULE21: returns restore PC in four clocks
`timescale 1ns/1ps
`default_nettype none
`include "cab_defines.svh"

module cab_core (
	input  wire logic             clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic             start_i,
	input  wire cab_pkg::cab_op_t op_i,
	input  wire logic [7:0]       rd_i,
	input  wire logic [7:0]       rr_i,
	input  wire logic [7:0]       imm_i,
	input  wire logic [15:0]      pair_i,
	input  wire logic [5:0]       word_imm_i,
	input  wire logic [7:0]       sreg_i,
	input  wire logic [15:0]      pc_i,
	input  wire logic [15:0]      z_i,
	input  wire logic [11:0]      offset_i,
	input  wire logic             next_two_word_i,
	input  wire logic [15:0]      stack_data_i,
	input  wire logic [5:0]       io_addr_i,
	input  wire logic [2:0]       io_bit_i,
	input  wire logic [7:0]       io_rdata_i,
	output logic                  ready_o,
	output logic                  done_o,
	output logic [7:0]            rd_data_o,
	output logic                  rd_we_o,
	output logic [15:0]           pair_data_o,
	output logic                  pair_we_o,
	output logic [7:0]            sreg_o,
	output logic [15:0]           pc_o,
	output logic                  stack_push_o,
	output logic                  stack_pop_o,
	output logic [15:0]           push_data_o,
	output logic                  io_we_o,
	output logic [5:0]            io_addr_o,
	output logic [7:0]            io_wmask_o,
	output logic [7:0]            io_wdata_o,
	output logic                  io_refused_o
);
	import cab_pkg::*;

	// ------------------------------------------------------------------
	// operand selection and arithmetic units
	// ------------------------------------------------------------------
	wire logic       as_sub;
	wire logic       as_imm;
	wire logic       as_cin;
	wire logic [7:0] as_a;
	wire logic [7:0] as_b;
	wire logic [7:0] as_res;
	wire logic       as_h;
	wire logic       as_v;
	wire logic       as_c;
	wire logic       io_ok;
	wire logic [7:0] io_mask;
	wire logic       io_val;
	wire logic       take;

	assign take   = start_i & ready_o;
	assign as_sub = (op_i != CAB_OP_SUM) & (op_i != CAB_OP_SUM_CARRY);
	assign as_imm = (op_i == CAB_OP_DIFFERENCE_IMM)
		| (op_i == CAB_OP_DIFF_BORROW_IMM);
	assign as_cin = ((op_i == CAB_OP_SUM_CARRY) | (op_i == CAB_OP_DIFF_BORROW)
		| (op_i == CAB_OP_DIFF_BORROW_IMM)) & sreg_i[`CAB_FLAG_C];
	assign as_a   = (op_i == CAB_OP_TWOS_INVERSION) ? `CAB_BYTE_ZERO : rd_i;
	assign as_b   = (op_i == CAB_OP_TWOS_INVERSION) ? rd_i
		: (as_imm ? imm_i : rr_i);

	cab_addsub8 i_cab_addsub8 (
		.sub_i   (as_sub),
		.a_i     (as_a),
		.b_i     (as_b),
		.cin_i   (as_cin),
		.res_o   (as_res),
		.half_o  (as_h),
		.ovf_o   (as_v),
		.carry_o (as_c)
	);

	cab_io_bit i_cab_io_bit (
		.addr_i     (io_addr_i),
		.bit_i      (io_bit_i),
		.rdata_i    (io_rdata_i),
		.in_range_o (io_ok),
		.mask_o     (io_mask),
		.bit_val_o  (io_val)
	);

	// ------------------------------------------------------------------
	// word arithmetic and program counter targets
	// ------------------------------------------------------------------
	wire logic        w_sub;
	wire logic [15:0] w_res;
	wire logic        w_v;
	wire logic        w_c;
	wire logic [15:0] pc_next;
	wire logic [15:0] pc_rel;
	wire logic [15:0] pc_skip;
	wire logic [2:0]  clk_skip;
	wire logic        io_hit;

	assign w_sub   = op_i == CAB_OP_WORD_DIFF_IMM;
	assign w_res   = w_sub ? pair_i - {10'h000, word_imm_i}
		: pair_i + {10'h000, word_imm_i};
	assign w_v     = w_sub ? (pair_i[15] & ~w_res[15])
		: (~pair_i[15] & w_res[15]);
	assign w_c     = w_sub ? (w_res[15] & ~pair_i[15])
		: (~w_res[15] & pair_i[15]);
	assign pc_next = pc_i + `CAB_PC_STEP;
	assign pc_rel  = pc_next + {{4{offset_i[11]}}, offset_i}; // RULE20
	assign pc_skip = pc_i + (next_two_word_i ? `CAB_SKIP_TWO : `CAB_SKIP_ONE);
	assign clk_skip = next_two_word_i ? `CAB_CLK_THREE : `CAB_CLK_TWO;
	assign io_hit  = io_ok & ((op_i == CAB_OP_IO_BIT_HIGH_SKIP) ? io_val
		: ~io_val); // RULE4

	// ------------------------------------------------------------------
	// result selection
	// ------------------------------------------------------------------
	logic [7:0]  res_d;
	logic        we_d;
	logic        pair_we_d;
	logic [7:0]  sreg_d;
	logic [15:0] pc_d;
	logic [2:0]  clk_d;
	logic        push_d;
	logic        pop_d;
	logic        io_we_d;
	logic        refused_d;
	logic [7:0]  lg;

	always_comb
	begin
		res_d = rd_i;
		we_d = 1'b0;
		pair_we_d = 1'b0;
		sreg_d = sreg_i;
		pc_d = pc_next;
		clk_d = `CAB_CLK_ONE;
		push_d = 1'b0;
		pop_d = 1'b0;
		io_we_d = 1'b0;
		refused_d = 1'b0;
		lg = rd_i;
		case (op_i)
		CAB_OP_SUM, CAB_OP_SUM_CARRY, CAB_OP_DIFFERENCE,
		CAB_OP_DIFFERENCE_IMM, CAB_OP_DIFF_BORROW, CAB_OP_DIFF_BORROW_IMM,
		CAB_OP_TWOS_INVERSION:
		begin
			res_d = as_res; // RULE6 RULE9 RULE10
			we_d = 1'b1;
			sreg_d[`CAB_FLAG_H] = as_h;
			sreg_d[`CAB_FLAG_V] = as_v;
			sreg_d[`CAB_FLAG_C] = as_c; // RULE18
		end
		CAB_OP_WORD_SUM_IMM, CAB_OP_WORD_DIFF_IMM:
		begin
			pair_we_d = 1'b1; // RULE7 RULE8
			clk_d = `CAB_CLK_TWO;
			sreg_d[`CAB_FLAG_V] = w_v;
			sreg_d[`CAB_FLAG_C] = w_c;
			sreg_d[`CAB_FLAG_S] = w_res[15] ^ w_v;
		end
		CAB_OP_CONJUNCTION, CAB_OP_ZERO_SIGN_CHECK:
		begin
			// test ands the destination with itself
			lg = rd_i & ((op_i == CAB_OP_ZERO_SIGN_CHECK) ? rd_i : rr_i); // RULE14
			sreg_d[`CAB_FLAG_V] = 1'b0;
			we_d = 1'b1;
		end
		CAB_OP_CONJUNCTION_IMM:
		begin
			lg = rd_i & imm_i;
			sreg_d[`CAB_FLAG_V] = 1'b0;
			we_d = 1'b1;
		end
		CAB_OP_DISJUNCTION:
		begin
			lg = rd_i | rr_i;
			sreg_d[`CAB_FLAG_V] = 1'b0;
			we_d = 1'b1;
		end
		CAB_OP_DISJUNCTION_IMM, CAB_OP_BITS_SET_MASK:
		begin
			lg = rd_i | imm_i; // RULE12
			sreg_d[`CAB_FLAG_V] = 1'b0;
			we_d = 1'b1;
		end
		CAB_OP_EXCL_DISJUNCTION:
		begin
			lg = rd_i ^ rr_i;
			sreg_d[`CAB_FLAG_V] = 1'b0;
			we_d = 1'b1;
		end
		CAB_OP_BITS_CLEAR_MASK:
		begin
			lg = rd_i & (`CAB_BYTE_ONES - imm_i); // RULE13
			sreg_d[`CAB_FLAG_V] = 1'b0;
			we_d = 1'b1;
		end
		CAB_OP_REGISTER_ZEROING:
		begin
			lg = rd_i ^ rd_i;
			sreg_d[`CAB_FLAG_V] = 1'b0;
			we_d = 1'b1;
		end
		CAB_OP_ONES_INVERSION:
		begin
			lg = `CAB_BYTE_ONES - rd_i; // RULE18
			sreg_d[`CAB_FLAG_V] = 1'b0;
			sreg_d[`CAB_FLAG_C] = 1'b1;
			we_d = 1'b1;
		end
		CAB_OP_PLUS_ONE:
		begin
			lg = rd_i + `CAB_BYTE_ONE; // RULE19
			sreg_d[`CAB_FLAG_V] = rd_i == `CAB_BYTE_MAXP;
			we_d = 1'b1;
		end
		CAB_OP_MINUS_ONE:
		begin
			lg = rd_i - `CAB_BYTE_ONE; // RULE19
			sreg_d[`CAB_FLAG_V] = rd_i == `CAB_BYTE_MINN;
			we_d = 1'b1;
		end
		CAB_OP_REGISTER_ALL_ONES:
		begin
			res_d = `CAB_BYTE_ONES;
			we_d = 1'b1;
		end
		CAB_OP_REL_BRANCH:
		begin
			pc_d = pc_rel;
			clk_d = `CAB_CLK_TWO;
		end
		CAB_OP_REL_SUB_ENTRY:
		begin
			pc_d = pc_rel;
			push_d = 1'b1;
			clk_d = `CAB_CLK_THREE;
		end
		CAB_OP_POINTER_BRANCH:
		begin
			pc_d = z_i; // RULE15
			clk_d = `CAB_CLK_TWO;
		end
		CAB_OP_PTR_SUB_ENTRY:
		begin
			pc_d = z_i; // RULE16
			push_d = 1'b1;
			clk_d = `CAB_CLK_THREE;
		end
		CAB_OP_SUBROUTINE_EXIT, CAB_OP_HANDLER_EXIT:
		begin
			pc_d = stack_data_i; // RULE21
			pop_d = 1'b1;
			clk_d = `CAB_CLK_FOUR;
			if (op_i == CAB_OP_HANDLER_EXIT)
				sreg_d[`CAB_FLAG_I] = 1'b1;
		end
		CAB_OP_EQUAL_SKIP:
		begin
			if (rd_i == rr_i)
			begin
				pc_d = pc_skip; // RULE17
				clk_d = clk_skip;
			end
		end
		CAB_OP_IO_BIT_SET, CAB_OP_IO_BIT_CLEAR:
		begin
			io_we_d = io_ok; // RULE3
			refused_d = ~io_ok;
			clk_d = `CAB_CLK_TWO;
		end
		CAB_OP_IO_BIT_HIGH_SKIP, CAB_OP_IO_BIT_LOW_SKIP:
		begin
			refused_d = ~io_ok;
			if (io_hit)
			begin
				pc_d = pc_skip; // RULE4
				clk_d = clk_skip;
			end
		end
		default:
		begin
			refused_d = 1'b1;
		end
		endcase
		if (we_d & (op_i != CAB_OP_REGISTER_ALL_ONES) & (res_d == rd_i))
			res_d = lg;
		if (we_d & (op_i != CAB_OP_REGISTER_ALL_ONES))
		begin
			sreg_d[`CAB_FLAG_Z] = res_d == `CAB_BYTE_ZERO;
			sreg_d[`CAB_FLAG_N] = res_d[7];
		end
		if (pair_we_d)
		begin
			sreg_d[`CAB_FLAG_Z] = w_res == `CAB_WORD_ZERO;
			sreg_d[`CAB_FLAG_N] = w_res[15];
		end
		if (op_i == CAB_OP_ZERO_SIGN_CHECK)
			we_d = 1'b0; // RULE14
	end

	// ------------------------------------------------------------------
	// result registers and cycle count
	// ------------------------------------------------------------------
	logic [2:0]  remain_q;
	logic [7:0]  res_q;
	logic        we_q;
	logic [15:0] pair_q;
	logic        pair_we_q;
	logic [7:0]  sreg_q;
	logic [15:0] pc_q;
	logic        push_q;
	logic        pop_q;
	logic [15:0] push_data_q;
	logic        io_we_q;
	logic [5:0]  io_addr_q;
	logic [7:0]  io_mask_q;
	logic [7:0]  io_data_q;
	logic        refused_q;

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			remain_q <= `CAB_CLK_NONE;
			res_q <= `CAB_BYTE_ZERO;
			we_q <= 1'b0;
			pair_q <= `CAB_WORD_ZERO;
			pair_we_q <= 1'b0;
			sreg_q <= `CAB_BYTE_ZERO;
			pc_q <= `CAB_WORD_ZERO;
			push_q <= 1'b0;
			pop_q <= 1'b0;
			push_data_q <= `CAB_WORD_ZERO;
			io_we_q <= 1'b0;
			io_addr_q <= `CAB_IO_ADDR_ZERO;
			io_mask_q <= `CAB_BYTE_ZERO;
			io_data_q <= `CAB_BYTE_ZERO;
			refused_q <= 1'b0;
		end
		else if (take)
		begin
			remain_q <= clk_d;
			res_q <= res_d;
			we_q <= we_d;
			pair_q <= w_res;
			pair_we_q <= pair_we_d;
			sreg_q <= sreg_d;
			pc_q <= pc_d;
			push_q <= push_d;
			pop_q <= pop_d;
			push_data_q <= pc_next; // RULE16 RULE20
			io_we_q <= io_we_d;
			io_addr_q <= io_addr_i;
			io_mask_q <= io_mask; // RULE5
			io_data_q <= (op_i == CAB_OP_IO_BIT_SET) ? io_mask
				: `CAB_BYTE_ZERO;
			refused_q <= refused_d;
		end
		else if (remain_q != `CAB_CLK_NONE)
			remain_q <= remain_q - `CAB_CLK_ONE;
	end

	// ------------------------------------------------------------------
	// outputs: strobes only while done_o
	// ------------------------------------------------------------------
	assign done_o       = remain_q == `CAB_CLK_ONE;
	assign ready_o      = remain_q <= `CAB_CLK_ONE;
	assign rd_data_o    = res_q;
	assign rd_we_o      = done_o & we_q;
	assign pair_data_o  = pair_q;
	assign pair_we_o    = done_o & pair_we_q;
	assign sreg_o       = sreg_q;
	assign pc_o         = pc_q;
	assign stack_push_o = done_o & push_q;
	assign stack_pop_o  = done_o & pop_q;
	assign push_data_o  = push_data_q;
	assign io_we_o      = done_o & io_we_q;
	assign io_addr_o    = io_addr_q;
	assign io_wmask_o   = io_mask_q;
	assign io_wdata_o   = io_data_q;
	assign io_refused_o = done_o & refused_q;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	adc_one_clock_a: assert property (take && op_i == CAB_OP_SUM_CARRY // RULE6
		|=> done_o && rd_data_o == $past(rd_i) + $past(rr_i)
		+ {7'h00, $past(sreg_i[`CAB_FLAG_C])}) else $error("adc result");
	word_two_clock_a: assert property (take && op_i == CAB_OP_WORD_SUM_IMM // RULE7
		|=> !done_o ##1 done_o && pair_we_o) else $error("word add timing");
	word_sub_res_a: assert property (take && w_sub // RULE8
		|=> ##1 pair_data_o == $past(pair_i, 2) - {10'h000, $past(word_imm_i, 2)})
		else $error("word sub result");
	logic_keep_c_a: assert property (take && op_i == CAB_OP_EXCL_DISJUNCTION // RULE11
		|=> sreg_o[`CAB_FLAG_C] == $past(sreg_i[`CAB_FLAG_C])
		&& !sreg_o[`CAB_FLAG_V]) else $error("logic flags");
	pointer_branch_pc_z_a: assert property (take && op_i == CAB_OP_POINTER_BRANCH // RULE15
		|=> !done_o ##1 done_o && pc_o == $past(z_i, 2)) else $error("pointer_branch");
	pointer_subroutine_entry_push_a: assert property (take && op_i == CAB_OP_PTR_SUB_ENTRY // RULE16
		|=> !done_o [*2] ##1 stack_push_o) else $error("pointer_subroutine_entry timing");
	ret_four_a: assert property (take && op_i == CAB_OP_HANDLER_EXIT // RULE21
		|=> !done_o [*3] ##1 done_o && sreg_o[`CAB_FLAG_I])
		else $error("handler_exit");
	io_range_a: assert property (io_we_o |-> io_addr_o <= `CAB_IO_BIT_LAST) // RULE3
		else $error("io range");
	io_onehot_a: assert property (io_we_o |-> $onehot(io_wmask_o)) // RULE5
		else $error("io mask");
	skip_pc_a: assert property (take && op_i == CAB_OP_EQUAL_SKIP // RULE17
		&& rd_i == rr_i && !next_two_word_i
		|=> !done_o ##1 done_o && pc_o == $past(pc_i, 2) + `CAB_SKIP_ONE)
		else $error("skip pc");

endmodule // cab_core

`default_nettype wire

// file: logic/cab_defines.svh
/*
 * Numeric constants of the ALU and program flow block: flag positions,
 * cycle counts, address limits and fixed operand values.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef CAB_DEFINES_SVH
`define CAB_DEFINES_SVH

// ----------------------------------------------------------------------
// status flag positions
// ----------------------------------------------------------------------
`define CAB_FLAG_C 0
`define CAB_FLAG_Z 1
`define CAB_FLAG_N 2
`define CAB_FLAG_V 3
`define CAB_FLAG_S 4
`define CAB_FLAG_H 5
`define CAB_FLAG_T 6
`define CAB_FLAG_I 7

// ----------------------------------------------------------------------
// cycles per instruction
// ----------------------------------------------------------------------
`define CAB_CLK_ONE   3'h1
`define CAB_CLK_TWO   3'h2
`define CAB_CLK_THREE 3'h3
`define CAB_CLK_FOUR  3'h4
`define CAB_CLK_NONE  3'h0

// ----------------------------------------------------------------------
// operand and address constants
// ----------------------------------------------------------------------
`define CAB_BYTE_ONES 8'hFF
`define CAB_BYTE_ZERO 8'h00
`define CAB_BYTE_ONE  8'h01
`define CAB_BYTE_MINN 8'h80
`define CAB_BYTE_MAXP 8'h7F
`define CAB_IO_BIT_LAST 6'h1F
`define CAB_IO_ADDR_ZERO 6'h00
`define CAB_PC_STEP   16'h0001
`define CAB_SKIP_ONE  16'h0002
`define CAB_SKIP_TWO  16'h0003
`define CAB_WORD_ZERO 16'h0000

`endif

// file: logic/cab_io_bit.sv
/*
 * Single-bit access decode for the low I/O range: range check, one-hot
 * write lane and the value of the addressed bit.
 * Assumes rdata_i holds the I/O register at addr_i.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cab_defines.svh"

module cab_io_bit (
	input  wire logic [5:0] addr_i,
	input  wire logic [2:0] bit_i,
	input  wire logic [7:0] rdata_i,
	output logic            in_range_o,
	output logic      [7:0] mask_o,
	output logic            bit_val_o
);

	assign in_range_o = addr_i <= `CAB_IO_BIT_LAST; // RULE3
	assign mask_o     = `CAB_BYTE_ONE << bit_i; // RULE5
	assign bit_val_o  = rdata_i[bit_i]; // RULE4

endmodule // cab_io_bit

`default_nettype wire

// file: logic/cab_pkg.sv
/*
 * Types of the ALU and program flow block: the instruction selector.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cab_pkg;

	typedef enum logic [5:0] {
		CAB_OP_SUM              = 6'b000000,
		CAB_OP_SUM_CARRY        = 6'b000001,
		CAB_OP_WORD_SUM_IMM     = 6'b000010,
		CAB_OP_DIFFERENCE       = 6'b000011,
		CAB_OP_DIFFERENCE_IMM   = 6'b000100,
		CAB_OP_DIFF_BORROW      = 6'b000101,
		CAB_OP_DIFF_BORROW_IMM  = 6'b000110,
		CAB_OP_WORD_DIFF_IMM    = 6'b000111,
		CAB_OP_CONJUNCTION      = 6'b001000,
		CAB_OP_CONJUNCTION_IMM  = 6'b001001,
		CAB_OP_DISJUNCTION      = 6'b001010,
		CAB_OP_DISJUNCTION_IMM  = 6'b001011,
		CAB_OP_EXCL_DISJUNCTION = 6'b001100,
		CAB_OP_ONES_INVERSION   = 6'b001101,
		CAB_OP_TWOS_INVERSION   = 6'b001110,
		CAB_OP_BITS_SET_MASK    = 6'b001111,
		CAB_OP_BITS_CLEAR_MASK  = 6'b010000,
		CAB_OP_PLUS_ONE         = 6'b010001,
		CAB_OP_MINUS_ONE        = 6'b010010,
		CAB_OP_ZERO_SIGN_CHECK  = 6'b010011,
		CAB_OP_REGISTER_ZEROING = 6'b010100,
		CAB_OP_REGISTER_ALL_ONES = 6'b010101,
		CAB_OP_REL_BRANCH       = 6'b010110,
		CAB_OP_POINTER_BRANCH   = 6'b010111,
		CAB_OP_REL_SUB_ENTRY    = 6'b011000,
		CAB_OP_PTR_SUB_ENTRY    = 6'b011001,
		CAB_OP_SUBROUTINE_EXIT  = 6'b011010,
		CAB_OP_HANDLER_EXIT     = 6'b011011,
		CAB_OP_EQUAL_SKIP       = 6'b011100,
		CAB_OP_IO_BIT_SET       = 6'b011101,
		CAB_OP_IO_BIT_CLEAR     = 6'b011110,
		CAB_OP_IO_BIT_HIGH_SKIP = 6'b011111,
		CAB_OP_IO_BIT_LOW_SKIP  = 6'b100000
	} cab_op_t;

endpackage
